// ---- verilog/pcscfg_top.sv ----
// 100 Mb/s coding sublayer configuration and status register
//
// Operation
// RQ1: bit 10 puts transmitter into true quiet
// RQ2: bit 9 forces signal detect reported
// RQ3: bit 8 picks enhanced detect; resets one
// RQ4: bit 7 selects 2ms else 722us timeout
// RQ5: bit 5 forces 100 Mb/s link good
// RQ6: bit 2 bypasses NRZI encode and decode
// RQ7: bits 15:13 ignore writes, read zero
// RQ8: software writes zero to reserved bits
module pcscfg_top
  import pcscfg_pkg::*;
#(
  parameter int SHORT_CYCLES = DTO_SHORT_CYCLES,
  parameter int LONG_CYCLES  = DTO_LONG_CYCLES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // line side inputs
  input  wire logic              line_signal_detect,
  input  wire logic              link_qualified,
  input  wire logic              descrambler_refresh,
  // configuration outputs
  output logic                   transmit_quiet_enable,
  output logic                   force_signal_detect,
  output logic                   signal_detect_algorithm_select,
  output logic                   descrambler_timeout_select,
  output logic                   force_good_link,
  output logic                   nrzi_bypass,
  // resulting status
  output logic                   pma_signal_detect,
  output logic                   link_good_100,
  output logic                   descrambler_sync_lost
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 5 || DATA_W != 16) begin : g_bad_port
    $error("pcscfg_top: register port widths not supported");
  end

  // a one-cycle window would reload to zero and never report a loss
  if (SHORT_CYCLES < 2 || LONG_CYCLES < 2) begin : g_bad_window
    $error("pcscfg_top: watchdog windows must be two cycles or more");
  end

  if (SHORT_CYCLES >= (1 << DTO_CNT_W) || LONG_CYCLES >= (1 << DTO_CNT_W)) begin : g_bad_count
    $error("pcscfg_top: watchdog windows do not fit the counter");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = (a == ADDR_W'(PCS_100M_CONFIG_STATUS_ADDR));
  endfunction : hit

  // the top three positions are never stored and always read as zero
  function automatic logic [15:0] storable(input logic [15:0] word);
    storable = word & CFG_WRITE_MASK;
  endfunction : storable

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  logic cfg_wr;
  logic cfg_rd;

  assign cfg_wr = wr && hit(addr);
  assign cfg_rd = rd && hit(addr);

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic [15:0] cfg;
  logic [15:0] next_cfg;

  // the reserved 'must be zero' bits are stored and read back so that
  // software doing read-modify-write sees what it wrote
  always_comb begin
    next_cfg = cfg;
    if (cfg_wr) begin
      next_cfg = storable(wdata); // [RQ7]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= CFG_RESET; // [RQ3]
    end else begin
      cfg <= next_cfg;
    end
  end

  // ----------------------------------------------------------------
  // read port: data stand one cycle after the strobe, only there
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;

  // anything but a read of this register drives zero, so a stale word
  // never lingers on the port after its one cycle
  always_comb begin
    next_rdata = '0;
    if (cfg_rd) begin
      next_rdata = storable(cfg); // [RQ7]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  // one flop per field; the copies lag the register by one cycle, which
  // keeps the long datapath fan-out off the register write path
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      transmit_quiet_enable <= CFG_RESET[TX_QUIET_BIT];
    end else begin
      transmit_quiet_enable <= cfg[TX_QUIET_BIT]; // [RQ1]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      force_signal_detect <= CFG_RESET[FSD_BIT];
    end else begin
      force_signal_detect <= cfg[FSD_BIT]; // [RQ2]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      signal_detect_algorithm_select <= CFG_RESET[SDALG_BIT];
    end else begin
      signal_detect_algorithm_select <= cfg[SDALG_BIT]; // [RQ3]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      descrambler_timeout_select <= CFG_RESET[DTO_BIT];
    end else begin
      descrambler_timeout_select <= cfg[DTO_BIT]; // [RQ4]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      force_good_link <= CFG_RESET[FGL_BIT];
    end else begin
      force_good_link <= cfg[FGL_BIT]; // [RQ5]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nrzi_bypass <= CFG_RESET[NRZI_BYP_BIT];
    end else begin
      nrzi_bypass <= cfg[NRZI_BYP_BIT]; // [RQ6]
    end
  end

  // ----------------------------------------------------------------
  // line signal detect synchroniser
  // ----------------------------------------------------------------
  logic sd_meta;
  logic sd_sync;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sd_meta <= 1'h0;
      sd_sync <= 1'h0;
    end else begin
      sd_meta <= line_signal_detect;
      sd_sync <= sd_meta;
    end
  end

  // ----------------------------------------------------------------
  // forced status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pma_signal_detect <= 1'h0;
    end else begin
      pma_signal_detect <= cfg[FSD_BIT] | sd_sync; // [RQ2]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_good_100 <= 1'h0;
    end else begin
      link_good_100 <= cfg[FGL_BIT] | link_qualified; // [RQ5]
    end
  end

  // ----------------------------------------------------------------
  // descrambler watchdog
  // ----------------------------------------------------------------
  // the timeout select is taken at each refresh, so a change applies from
  // the next refresh on and never cuts a running window short
  pcscfg_sync_timer #(
    .CNT_W        (DTO_CNT_W),
    .SHORT_CYCLES (SHORT_CYCLES),
    .LONG_CYCLES  (LONG_CYCLES)
  ) u_timer (
    .clk       (clk),
    .nrst      (nrst),
    .long_sel  (cfg[DTO_BIT]), // [RQ4]
    .refresh   (descrambler_refresh),
    .sync_lost (descrambler_sync_lost)
  );
endmodule : pcscfg_top

// ---- verilog/pcscfg_pkg.sv ----
// constants for the 100 Mb/s coding sublayer configuration register
package pcscfg_pkg;
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W              = 5;
  localparam int          DATA_W              = 16;
  localparam logic [4:0]  PCS_100M_CONFIG_STATUS_ADDR = 5'h16;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TX_QUIET_BIT = 10;
  localparam int FSD_BIT      = 9;
  localparam int SDALG_BIT    = 8;
  localparam int DTO_BIT      = 7;
  localparam int FGL_BIT      = 5;
  localparam int NRZI_BYP_BIT = 2;

  // ----------------------------------------------------------------
  // reset value and write mask
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_RESET      = 16'h0100;
  // bits 15:13 are never stored; reserved bits 12,11,6,4,3,1,0 are kept
  localparam logic [15:0] CFG_WRITE_MASK = 16'h1FFF;

  // ----------------------------------------------------------------
  // descrambler timeout
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int DTO_SHORT_NS     = 722000;
  localparam int DTO_LONG_NS      = 2000000;
  localparam int DTO_SHORT_CYCLES = DTO_SHORT_NS / CLK_PERIOD_NS;
  localparam int DTO_LONG_CYCLES  = DTO_LONG_NS / CLK_PERIOD_NS;
  localparam int DTO_CNT_W        = 16;
endpackage : pcscfg_pkg

// ---- verilog/pcscfg_sync_timer.sv ----
// descrambler loss-of-sync watchdog with selectable timeout
module pcscfg_sync_timer
  import pcscfg_pkg::*;
#(
  parameter int CNT_W        = DTO_CNT_W,
  parameter int SHORT_CYCLES = DTO_SHORT_CYCLES,
  parameter int LONG_CYCLES  = DTO_LONG_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // control
  input  wire logic long_sel,
  input  wire logic refresh,
  // status
  output logic      sync_lost
);
  // a one-cycle window would reload to zero and never time out
  if (SHORT_CYCLES < 2 || LONG_CYCLES < 2 ||
      LONG_CYCLES >= (1 << CNT_W) || SHORT_CYCLES >= (1 << CNT_W)) begin : g_bad_counts
    $error("pcscfg_sync_timer: timeout counts do not fit the counter");
  end

  logic [CNT_W-1:0] remain;
  logic [CNT_W-1:0] load_value;

  // [RQ4]
  assign load_value = long_sel ? CNT_W'(LONG_CYCLES - 1) : CNT_W'(SHORT_CYCLES - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remain <= '0;
    end else if (refresh) begin
      remain <= load_value; // [RQ4]
    end else if (remain != '0) begin
      remain <= remain - CNT_W'(1);
    end
  end

  // lost once the window runs out with no refresh; a refresh clears it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_lost <= 1'h1;
    end else if (refresh) begin
      sync_lost <= 1'h0;
    end else if (remain == CNT_W'(1)) begin
      sync_lost <= 1'h1; // [RQ4]
    end
  end
endmodule : pcscfg_sync_timer

// ---- bench/pcscfg_properties.sv ----
// assertion checker for the coding sublayer configuration register
module pcscfg_properties
  import pcscfg_pkg::*;
#(
  parameter int SHORT_CYCLES = DTO_SHORT_CYCLES,
  parameter int LONG_CYCLES  = DTO_LONG_CYCLES
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  // watchdog, configuration and status
  input wire logic              descrambler_refresh,
  input wire logic              transmit_quiet_enable,
  input wire logic              force_signal_detect,
  input wire logic              signal_detect_algorithm_select,
  input wire logic              descrambler_timeout_select,
  input wire logic              force_good_link,
  input wire logic              nrzi_bypass,
  input wire logic              pma_signal_detect,
  input wire logic              link_good_100,
  input wire logic              descrambler_sync_lost
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire hit = addr == PCS_100M_CONFIG_STATUS_ADDR;
  // cycles since the last refresh; saturates so reset reads as long expired
  int since;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) since <= 1 << 20;
    else if (descrambler_refresh) since <= 0;
    else if (since < (1 << 20)) since <= since + 1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_cfg;
    wr && hit |-> ##2 {transmit_quiet_enable, force_signal_detect, signal_detect_algorithm_select,
      descrambler_timeout_select} == $past(wdata[10:7], 2) && force_good_link == $past(wdata[5], 2)
      && nrzi_bypass == $past(wdata[2], 2);
  endproperty
  property p_fsd; force_signal_detect ##1 force_signal_detect |-> pma_signal_detect; endproperty
  property p_fgl; force_good_link ##1 force_good_link |-> link_good_100; endproperty
  property p_dto_s;
    since == SHORT_CYCLES - 1 && !descrambler_timeout_select |-> descrambler_sync_lost;
  endproperty
  property p_dto_l;
    since == LONG_CYCLES - 1 && descrambler_timeout_select |-> descrambler_sync_lost;
  endproperty
  property p_fresh; since < SHORT_CYCLES - 1 |-> !descrambler_sync_lost; endproperty
  property p_rd;
    rd && hit |=> rdata[15:13] == 3'h0 && rdata[2] == nrzi_bypass && rdata[5] == force_good_link
      && rdata[10:7] == {transmit_quiet_enable, force_signal_detect,
      signal_detect_algorithm_select, descrambler_timeout_select};
  endproperty
  property p_idle; !(rd && hit) |=> rdata == 16'h0000; endproperty
  a_cfg: assert property (p_cfg) else $error("outputs differ from write");
  a_fsd: assert property (p_fsd) else $error("forced signal detect not reported");
  a_fgl: assert property (p_fgl) else $error("forced good link not reported");
  a_dto_s: assert property (p_dto_s) else $error("short timeout missed");
  a_dto_l: assert property (p_dto_l) else $error("long timeout missed");
  a_fresh: assert property (p_fresh) else $error("sync lost too early");
  a_rd: assert property (p_rd) else $error("read data differs from fields");
  a_idle: assert property (p_idle) else $error("read data not zero");
  c_wr: cover property (wr && hit);
  c_rd: cover property (rd && hit);
  c_lost: cover property ($rose(descrambler_sync_lost));
endmodule : pcscfg_properties

bind pcscfg_top pcscfg_properties #(.SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) chk_u (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .descrambler_refresh(descrambler_refresh), .transmit_quiet_enable(transmit_quiet_enable),
  .force_signal_detect(force_signal_detect), .force_good_link(force_good_link),
  .signal_detect_algorithm_select(signal_detect_algorithm_select), .nrzi_bypass(nrzi_bypass),
  .descrambler_timeout_select(descrambler_timeout_select), .link_good_100(link_good_100),
  .pma_signal_detect(pma_signal_detect), .descrambler_sync_lost(descrambler_sync_lost));

// ---- bench/pcscfg_bench.sv ----
// self-checking bench for the coding sublayer configuration register
module pcscfg_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // short watchdog counts keep the run brief
  localparam int SC = 5;
  localparam int LC = 12;
  logic        clk, nrst, wr, rd, lsd, lq, refr, tq, fsd, sda, dto, fgl, nbyp, pma, lg, lost;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata;
  int          errors, checks, cyc;
  pcscfg_top #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC)) dut_u (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .line_signal_detect(lsd), .link_qualified(lq), .descrambler_refresh(refr),
    .transmit_quiet_enable(tq), .force_signal_detect(fsd), .signal_detect_algorithm_select(sda),
    .descrambler_timeout_select(dto), .force_good_link(fgl), .nrzi_bypass(nbyp),
    .pma_signal_detect(pma), .link_good_100(lg), .descrambler_sync_lost(lost));
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wreg(logic [4:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // read leaves the config outputs settled from any write just before
  task automatic rreg(logic [4:0] a, logic [15:0] exp, logic [5:0] cfg);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
    chk("cfg", {10'h0, cfg}, {10'h0, tq, fsd, sda, dto, fgl, nbyp});
    @(posedge clk);
    #1 chk("rdata after read", 16'h0000, rdata);
  endtask : rreg
  task automatic t_fields();
    rreg(5'h16, 16'h0100, 6'h08);
    chk("lost", 16'h1, {15'h0, lost});
    wreg(5'h16, 16'hE7A4);
    rreg(5'h16, 16'h07A4, 6'h3F);
    chk("forced", 16'h3, {14'h0, pma, lg});
    wreg(5'h15, 16'h0400);
    rreg(5'h15, 16'h0000, 6'h3F);
    wreg(5'h16, 16'h0000);
    rreg(5'h16, 16'h0000, 6'h00);
  endtask : t_fields
  task automatic t_line(logic v);
    @(posedge clk);
    lsd <= v;
    lq <= v;
    repeat (4) @(posedge clk);
    #1 chk("line", {14'h0, v, v}, {14'h0, pma, lg});
  endtask : t_line
  task automatic t_timeout(logic sel, int n);
    int k;
    wreg(5'h16, {8'h01, sel, 7'h00});
    repeat (2) @(posedge clk);
    refr <= 1'b1;
    @(posedge clk);
    refr <= 1'b0;
    k = 1;
    #1 chk("lost early", 16'h0, {15'h0, lost});
    while (lost !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
      #1;
    end
    chk("timeout", 16'(n), 16'(k));
  endtask : t_timeout
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    {nrst, wr, rd, lsd, lq, refr, addr, wdata} = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_fields();
    t_line(1'b1);
    t_line(1'b0);
    t_timeout(1'b0, SC);
    t_timeout(1'b1, LC);
    wrap_up();
  end
endmodule : pcscfg_bench
